// >>> logic/arc_sine_decode.sv
`timescale 1ns/100ps
module arc_sine_decode
  import arc_sine_pkg::*;
#(
  parameter logic [2:0] MY_CPID = DEFAULT_CPID
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic ISSUE_VALID,
  input wire logic [15:0] OP_WORD,
  input wire logic [15:0] CMD_WORD,
  output logic ACCEPT,
  output logic ILLEGAL,
  output logic [2:0] SRC_REG,
  output logic [2:0] DST_REG,
  output logic MEM_SRC,
  output logic [2:0] SRC_FMT,
  output logic [5:0] EA_FIELD,
  output logic NEED_CONVERT,
  input wire logic OPERAND_VALID,
  input wire logic [79:0] OPERAND_EXT,
  input wire logic [79:0] CORE_RESULT,
  input wire side_flags_t CORE_FLAGS,
  output logic RESULT_WE,
  output logic [2:0] RESULT_REG,
  output logic [79:0] RESULT_DATA,
  output logic [31:0] STATUS
);

  // Fields of the two instruction words.
  logic line_ok;
  logic cpid_ok;
  logic ext_ok;
  decoded_t dec;
  logic ea_legal;
  logic fmt_legal;
  logic dreg_fmt_ok;

  // Instruction held between issue and operand arrival.
  decoded_t held_q;
  logic busy_q;

  // Registered outputs.
  logic accept_q;
  logic illegal_q;
  logic result_we_q;
  logic [79:0] result_q;
  logic [31:0] status_q;

  // Operand classification.
  logic op_sign;
  logic [14:0] op_exp;
  logic [63:0] op_mant;
  logic op_is_nan;
  logic op_is_inf;
  logic op_is_zero;
  logic op_out_range;
  logic [79:0] res_d;
  logic [7:0] exc_d;
  logic [3:0] cc_d;

  // Opcode decode of the line code, identifier and operation extension.
  always_comb begin
    line_ok = (OP_WORD[OP_LINE_HI:OP_LINE_LO] == LINE_F_CODE);
    cpid_ok = (OP_WORD[OP_CPID_HI:OP_CPID_LO] == MY_CPID);
    ext_ok = (CMD_WORD[CMD_EXT_HI:CMD_EXT_LO] == ARC_SINE_EXT);
    dec.mem_src = CMD_WORD[CMD_RM_BIT];
    dec.src_spec = CMD_WORD[CMD_SRC_HI:CMD_SRC_LO];
    dec.dst_reg = CMD_WORD[CMD_DST_HI:CMD_DST_LO];
    dec.ea_mode = OP_WORD[OP_EAMODE_HI:OP_EAMODE_LO];
    dec.ea_reg = OP_WORD[OP_EAREG_HI:OP_EAREG_LO];
  end

  // Legality of the addressing mode and source format in memory mode.
  always_comb begin
    fmt_legal = (dec.src_spec != FMT_ILLEGAL);
    dreg_fmt_ok = (dec.src_spec == FMT_LONG) || (dec.src_spec == FMT_SINGLE) ||
                  (dec.src_spec == FMT_WORD) || (dec.src_spec == FMT_BYTE);
    if (dec.ea_mode == EA_DATA_REG) begin
      // Data register direct carries at most 32 bits of operand.
      ea_legal = dreg_fmt_ok;
    end else if (dec.ea_mode == EA_ADDR_REG) begin
      // Address register direct is never a source here.
      ea_legal = 1'b0;
    end else if (dec.ea_mode == EA_EXTENDED) begin
      // Only the five defined extended sub-modes are legal.
      ea_legal = (dec.ea_reg == EA_ABS_SHORT) || (dec.ea_reg == EA_ABS_LONG) ||
                 (dec.ea_reg == EA_IMMEDIATE) || (dec.ea_reg == EA_PC_DISP) ||
                 (dec.ea_reg == EA_PC_INDEX);
    end else begin
      // Memory-indirect forms through an address register.
      ea_legal = 1'b1;
    end
  end

  // Issue handshake: accept when the instruction belongs here and the unit is not busy.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      accept_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      // Instructions for another coprocessor are neither accepted nor flagged.
      accept_q <= ISSUE_VALID && !busy_q && line_ok && cpid_ok && ext_ok;
      illegal_q <= ISSUE_VALID && !busy_q && line_ok && cpid_ok && ext_ok &&
                   dec.mem_src && !(ea_legal && fmt_legal);
    end
  end

  // Holding register for the instruction waiting on its operand.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      busy_q <= 1'b0;
      held_q <= '0;
    end else if (ISSUE_VALID && !busy_q && line_ok && cpid_ok && ext_ok) begin
      // Illegal memory forms are dropped rather than executed.
      busy_q <= !dec.mem_src || (ea_legal && fmt_legal);
      held_q <= dec;
    end else if (busy_q && OPERAND_VALID) begin
      busy_q <= 1'b0;
    end
  end

  // Classification of the extended-precision operand.
  always_comb begin
    op_sign = OPERAND_EXT[EXT_SIGN_BIT];
    op_exp = OPERAND_EXT[EXT_EXP_HI:EXT_EXP_LO];
    op_mant = OPERAND_EXT[63:0];
    op_is_nan = (op_exp == EXP_ALL_ONES) && (op_mant[62:0] != MANT_ZERO[62:0]);
    op_is_inf = (op_exp == EXP_ALL_ONES) && (op_mant[62:0] == MANT_ZERO[62:0]);
    op_is_zero = (op_mant == MANT_ZERO);
    // Magnitude above one: exponent past the bias, or equal with fraction.
    op_out_range = op_is_inf || (!op_is_nan && ((op_exp > EXP_BIAS) ||
                   ((op_exp == EXP_BIAS) && (op_mant > MANT_ONE))));
  end

  // Result selection and exception byte for the completed operation.
  always_comb begin
    exc_d = '0;
    if (op_is_nan) begin
      // A NaN source passes through, quieted.
      res_d = OPERAND_EXT | {16'h_0000, 2'b01, 62'h0};
    end else if (op_out_range) begin
      res_d = DEFAULT_NAN;
    end else if (op_is_zero) begin
      res_d = {op_sign, 79'h0};
    end else begin
      // The core bounds its output to the half-pi interval.
      res_d = CORE_RESULT;
    end
    exc_d[EXC_UNORDERED_BRANCH_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
    exc_d[EXC_SIGNALING_NAN_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = CORE_FLAGS.signaling_nan_flag;
    exc_d[EXC_OPERAND_ERROR_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = op_out_range;
    exc_d[EXC_OVERFLOW_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
    exc_d[EXC_UNDERFLOW_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
    exc_d[EXC_DZ - EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
    exc_d[EXC_INEXACT_RESULT_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = CORE_FLAGS.inexact_result_flag && !op_out_range && !op_is_zero;
    exc_d[EXC_INEXACT_DECIMAL_INPUT_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] = held_q.mem_src && (held_q.src_spec == FMT_PACKED) &&
                                   CORE_FLAGS.inexact_decimal_input_flag;
    cc_d[CC_N] = res_d[EXT_SIGN_BIT];
    cc_d[CC_Z] = (res_d[63:0] == MANT_ZERO) && (res_d[EXT_EXP_HI:EXT_EXP_LO] == '0);
    cc_d[CC_I] = 1'b0;
    cc_d[CC_NAN] = op_is_nan || op_out_range;
  end

  // Result write-back to the destination register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      result_we_q <= 1'b0;
      result_q <= '0;
    end else begin
      result_we_q <= busy_q && OPERAND_VALID;
      if (busy_q && OPERAND_VALID) begin
        result_q <= res_d;
      end
    end
  end

  // Status register update: exception, accrued, condition codes.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      status_q <= STATUS_RESET;
    end else if (busy_q && OPERAND_VALID) begin
      status_q[EXC_UNORDERED_BRANCH_FLAG:EXC_INEXACT_DECIMAL_INPUT_FLAG] <= exc_d;
      status_q[CC_HI:CC_LO] <= cc_d;
      status_q[ACC_IOP] <= status_q[ACC_IOP] | exc_d[EXC_SIGNALING_NAN_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] |
                           exc_d[EXC_OPERAND_ERROR_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG];
      status_q[ACC_OVERFLOW_FLAG] <= status_q[ACC_OVERFLOW_FLAG] | exc_d[EXC_OVERFLOW_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG];
      status_q[ACC_UNDERFLOW_FLAG] <= status_q[ACC_UNDERFLOW_FLAG] | (exc_d[EXC_UNDERFLOW_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] &
                            exc_d[EXC_INEXACT_RESULT_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG]);
      status_q[ACC_DZ] <= status_q[ACC_DZ] | exc_d[EXC_DZ - EXC_INEXACT_DECIMAL_INPUT_FLAG];
      status_q[ACC_INEX] <= status_q[ACC_INEX] | exc_d[EXC_INEXACT_RESULT_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] |
                            exc_d[EXC_INEXACT_DECIMAL_INPUT_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG] | exc_d[EXC_OVERFLOW_FLAG - EXC_INEXACT_DECIMAL_INPUT_FLAG];
    end
  end

  // Register-mode source number; equal fields share one register.
  assign SRC_REG = held_q.mem_src ? held_q.dst_reg : held_q.src_spec;
  assign SRC_FMT = held_q.src_spec;
  assign MEM_SRC = held_q.mem_src;
  assign EA_FIELD = {held_q.ea_mode, held_q.ea_reg};
  // Every memory operand except extended precision needs conversion; register sources need none.
  assign NEED_CONVERT = held_q.mem_src && (held_q.src_spec != FMT_EXTENDED);
  assign DST_REG = held_q.dst_reg;
  assign RESULT_REG = held_q.dst_reg;
  assign ACCEPT = accept_q;
  assign ILLEGAL = illegal_q;
  assign RESULT_WE = result_we_q;
  assign RESULT_DATA = result_q;
  assign STATUS = status_q;

endmodule

// >>> logic/arc_sine_pkg.sv
package arc_sine_pkg;

  // Opcode word layout: fixed line bits, coprocessor id, effective address.
  localparam logic [3:0] LINE_F_CODE = 4'h_F;
  localparam int OP_LINE_HI = 15;
  localparam int OP_LINE_LO = 12;
  localparam int OP_CPID_HI = 11;
  localparam int OP_CPID_LO = 9;
  localparam int OP_EAMODE_HI = 5;
  localparam int OP_EAMODE_LO = 3;
  localparam int OP_EAREG_HI = 2;
  localparam int OP_EAREG_LO = 0;

  // Command word layout: operand-location select, source, destination, operation extension.
  localparam int CMD_RM_BIT = 14;
  localparam int CMD_SRC_HI = 12;
  localparam int CMD_SRC_LO = 10;
  localparam int CMD_DST_HI = 9;
  localparam int CMD_DST_LO = 7;
  localparam int CMD_EXT_HI = 6;
  localparam int CMD_EXT_LO = 0;
  localparam logic [6:0] ARC_SINE_EXT = 7'h_0C;

  // Default coprocessor identifier of the floating-point unit.
  localparam logic [2:0] DEFAULT_CPID = 3'h_1;

  // Source data formats selected when the operand comes from memory.
  typedef enum logic [2:0] {
    FMT_LONG = 3'b000,
    FMT_SINGLE = 3'b001,
    FMT_EXTENDED = 3'b010,
    FMT_PACKED = 3'b011,
    FMT_WORD = 3'b100,
    FMT_DOUBLE = 3'b101,
    FMT_BYTE = 3'b110,
    FMT_ILLEGAL = 3'b111
  } src_fmt_t;

  // Addressing mode field values.
  localparam logic [2:0] EA_DATA_REG = 3'b000;
  localparam logic [2:0] EA_ADDR_REG = 3'b001;
  localparam logic [2:0] EA_EXTENDED = 3'b111;
  localparam logic [2:0] EA_ABS_SHORT = 3'b000;
  localparam logic [2:0] EA_ABS_LONG = 3'b001;
  localparam logic [2:0] EA_PC_DISP = 3'b010;
  localparam logic [2:0] EA_PC_INDEX = 3'b011;
  localparam logic [2:0] EA_IMMEDIATE = 3'b100;

  // Extended-precision operand layout.
  localparam int EXT_SIGN_BIT = 79;
  localparam int EXT_EXP_HI = 78;
  localparam int EXT_EXP_LO = 64;
  localparam logic [14:0] EXP_ALL_ONES = 15'h_7FFF;
  localparam logic [14:0] EXP_BIAS = 15'h_3FFF;
  localparam logic [63:0] MANT_ONE = 64'h_8000_0000_0000_0000;
  localparam logic [63:0] MANT_ZERO = 64'h_0000_0000_0000_0000;
  localparam logic [79:0] DEFAULT_NAN = 80'h_7FFF_FFFF_FFFF_FFFF_FFFF;

  // Exception byte, quotient, condition-code and accrued bit positions within the status register.
  localparam int EXC_UNORDERED_BRANCH_FLAG = 15;
  localparam int EXC_SIGNALING_NAN_FLAG = 14;
  localparam int EXC_OPERAND_ERROR_FLAG = 13;
  localparam int EXC_OVERFLOW_FLAG = 12;
  localparam int EXC_UNDERFLOW_FLAG = 11;
  localparam int EXC_DZ = 10;
  localparam int EXC_INEXACT_RESULT_FLAG = 9;
  localparam int EXC_INEXACT_DECIMAL_INPUT_FLAG = 8;
  localparam int QUOT_HI = 23;
  localparam int QUOT_LO = 16;
  localparam int CC_HI = 27;
  localparam int CC_LO = 24;
  localparam int ACC_IOP = 7;
  localparam int ACC_OVERFLOW_FLAG = 6;
  localparam int ACC_UNDERFLOW_FLAG = 5;
  localparam int ACC_DZ = 4;
  localparam int ACC_INEX = 3;
  localparam logic [31:0] STATUS_RESET = 32'h_0000_0000;

  // Condition-code bits: negative, zero, infinity, not-a-number.
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_I = 1;
  localparam int CC_NAN = 0;

  // Decoded instruction as carried through the block.
  typedef struct packed {
    logic mem_src;
    logic [2:0] src_spec;
    logic [2:0] dst_reg;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
  } decoded_t;

  // Arithmetic side-results fed back from the datapath.
  typedef struct packed {
    logic signaling_nan_flag;
    logic underflow_flag;
    logic inexact_result_flag;
    logic inexact_decimal_input_flag;
  } side_flags_t;

endpackage

// >>> sim/arc_sine_assertions.sv
`timescale 1ns/100ps
// Checks the issue, operand and status relations at the decoder ports.
module arc_sine_assertions
  import arc_sine_pkg::*;
#(
  parameter logic [2:0] MY_CPID = DEFAULT_CPID
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic ISSUE_VALID,
  input wire logic [15:0] OP_WORD,
  input wire logic [15:0] CMD_WORD,
  input wire logic ACCEPT,
  input wire logic ILLEGAL,
  input wire logic [2:0] SRC_REG,
  input wire logic [2:0] DST_REG,
  input wire logic MEM_SRC,
  input wire logic [2:0] SRC_FMT,
  input wire logic [5:0] EA_FIELD,
  input wire logic NEED_CONVERT,
  input wire logic OPERAND_VALID,
  input wire logic [79:0] OPERAND_EXT,
  input wire logic [79:0] CORE_RESULT,
  input wire side_flags_t CORE_FLAGS,
  input wire logic RESULT_WE,
  input wire logic [2:0] RESULT_REG,
  input wire logic [79:0] RESULT_DATA,
  input wire logic [31:0] STATUS
);
  logic busy_q; // Mirror of the unit's busy state.
  logic busy;
  logic take; // An operand is consumed on this edge.
  logic good; // Words address this unit and this operation.
  logic out_rng; // Infinity or magnitude above one.
  logic [15:0] cmd_q; // Command word seen at the previous edge.
  logic [14:0] ex;
  assign ex = OPERAND_EXT[78:64];
  assign busy = busy_q | (ACCEPT & ~ILLEGAL);
  assign take = busy & OPERAND_VALID;
  assign good = OP_WORD[15:12] == LINE_F_CODE && OP_WORD[11:9] == MY_CPID && CMD_WORD[6:0] == ARC_SINE_EXT;
  assign out_rng = ex == EXP_ALL_ONES ? OPERAND_EXT[62:0] == 0 : ex > EXP_BIAS || (ex == EXP_BIAS && OPERAND_EXT[63:0] > MANT_ONE);
  // The busy mirror clears when an operand is taken.
  always_ff @(posedge CLK) begin
    busy_q <= SRST ? 1'b0 : busy & ~OPERAND_VALID;
    cmd_q <= CMD_WORD;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  AST_ACCEPT: assert property (ISSUE_VALID && good && !busy |=> ACCEPT)
    else $error("matching issue not accepted");
  AST_REFUSE: assert property (ISSUE_VALID && (busy || !good) |=> !ACCEPT)
    else $error("refused issue accepted");
  AST_FIELDS: assert property (ACCEPT |-> MEM_SRC == cmd_q[14] && DST_REG == cmd_q[9:7])
    else $error("held select or destination wrong");
  AST_SRC_REG: assert property (ACCEPT && !MEM_SRC |-> SRC_REG == cmd_q[12:10])
    else $error("source register wrong");
  AST_FMT: assert property (ACCEPT && MEM_SRC |-> SRC_FMT == cmd_q[12:10])
    else $error("source format wrong");
  AST_CONVERT: assert property (ACCEPT && MEM_SRC && !ILLEGAL |-> NEED_CONVERT == (cmd_q[12:10] != FMT_EXTENDED))
    else $error("conversion flag wrong");
  AST_RESULT: assert property (take |=> RESULT_WE && RESULT_REG == $past(DST_REG) ##1 !RESULT_WE)
    else $error("result write missing or wrong");
  AST_NAN: assert property (take && out_rng |=> STATUS[EXC_OPERAND_ERROR_FLAG] && RESULT_DATA == DEFAULT_NAN)
    else $error("out of range source not flagged");
  AST_NO_OPERAND_ERROR_FLAG: assert property (take && !out_rng && ex != EXP_ALL_ONES |=> !STATUS[EXC_OPERAND_ERROR_FLAG])
    else $error("operand error on in-range source");
  AST_CLEARED: assert property (RESULT_WE |-> !STATUS[EXC_UNORDERED_BRANCH_FLAG] && !STATUS[EXC_OVERFLOW_FLAG] && !STATUS[EXC_DZ])
    else $error("cleared exception bit set");
  AST_QUOT: assert property (RESULT_WE |-> STATUS[QUOT_HI:QUOT_LO] == 8'h_00)
    else $error("quotient byte changed");
  AST_ACCRUED: assert property (RESULT_WE && STATUS[EXC_OPERAND_ERROR_FLAG] |-> STATUS[ACC_IOP])
    else $error("accrued invalid bit missing");
  cover property (take && out_rng);
  cover property (ACCEPT && ILLEGAL);
  cover property (ACCEPT && SRC_FMT == FMT_PACKED && MEM_SRC);
  cover property (take && ex == EXP_ALL_ONES && OPERAND_EXT[62:0] != 0);
endmodule

bind arc_sine_decode arc_sine_assertions #(.MY_CPID(MY_CPID)) u_chk (.CLK(CLK), .SRST(SRST),
  .ISSUE_VALID(ISSUE_VALID), .OP_WORD(OP_WORD), .CMD_WORD(CMD_WORD), .ACCEPT(ACCEPT), .ILLEGAL(ILLEGAL),
  .SRC_REG(SRC_REG), .DST_REG(DST_REG), .MEM_SRC(MEM_SRC), .SRC_FMT(SRC_FMT), .EA_FIELD(EA_FIELD),
  .NEED_CONVERT(NEED_CONVERT), .OPERAND_VALID(OPERAND_VALID), .OPERAND_EXT(OPERAND_EXT),
  .CORE_RESULT(CORE_RESULT), .CORE_FLAGS(CORE_FLAGS), .RESULT_WE(RESULT_WE), .RESULT_REG(RESULT_REG),
  .RESULT_DATA(RESULT_DATA), .STATUS(STATUS));

// >>> sim/issuer_model.sv
`timescale 1ns/100ps
// Main processor side: issues words and hands over operands.
module issuer_model
  import arc_sine_pkg::*;
(
  input wire logic clk,
  output logic issue_valid,
  output logic [15:0] op_word,
  output logic [15:0] cmd_word,
  output logic operand_valid,
  output logic [79:0] operand_ext,
  output logic [79:0] core_result,
  output side_flags_t core_flags
);
  // Everything starts idle.
  initial begin
    issue_valid = 1'b0;
    op_word = 16'h_0000;
    cmd_word = 16'h_0000;
    operand_valid = 1'b0;
    operand_ext = '0;
    core_result = '0;
    core_flags = '0;
  end
  // Presents both words for one edge; released words are inverted.
  task automatic issue(input logic [15:0] ow, input logic [15:0] cw);
    @(posedge clk);
    issue_valid <= 1'b1;
    op_word <= cw[14] ? ow : {ow[15:6], 6'h_00};
    cmd_word <= cw;
    @(posedge clk);
    issue_valid <= 1'b0;
    op_word <= ~ow;
    cmd_word <= ~cw;
    #1;
  endtask
  // Hands over one extended operand with the core's answer.
  task automatic give(input logic [79:0] x, input logic [79:0] core, input side_flags_t fl);
    @(posedge clk);
    operand_valid <= 1'b1;
    operand_ext <= x;
    core_result <= core;
    core_flags <= fl;
    @(posedge clk);
    operand_valid <= 1'b0;
    operand_ext <= ~x;
    #1;
  endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
// Drives the decoder through the issuer model and checks each result.
module testbench;
  import arc_sine_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic iv, ov, acc, ill, mem_src, conv, we;
  logic [15:0] ow, cw;
  logic [79:0] opx, core, rdata;
  side_flags_t flags;
  logic [2:0] sreg, dreg, fmt, rreg;
  logic [5:0] ea;
  logic [31:0] status;
  logic iop_acc = 1'b0; // Accrued invalid bit as the model sees it.
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  issuer_model issuer (.clk(clk), .issue_valid(iv), .op_word(ow), .cmd_word(cw), .operand_valid(ov),
    .operand_ext(opx), .core_result(core), .core_flags(flags));
  arc_sine_decode dut (.CLK(clk), .SRST(srst), .ISSUE_VALID(iv), .OP_WORD(ow), .CMD_WORD(cw), .ACCEPT(acc),
    .ILLEGAL(ill), .SRC_REG(sreg), .DST_REG(dreg), .MEM_SRC(mem_src), .SRC_FMT(fmt), .EA_FIELD(ea),
    .NEED_CONVERT(conv), .OPERAND_VALID(ov), .OPERAND_EXT(opx), .CORE_RESULT(core), .CORE_FLAGS(flags),
    .RESULT_WE(we), .RESULT_REG(rreg), .RESULT_DATA(rdata), .STATUS(status));
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  // Expected arc sine result by source class; a NaN source comes back quieted.
  function automatic logic [79:0] model(input logic [79:0] x, input logic [79:0] c);
    if (x[78:64] == EXP_ALL_ONES && x[62:0] != 0) return x | {16'h_0000, 2'b01, 62'h0};
    if (x[78:64] == EXP_ALL_ONES || x[78:64] > EXP_BIAS || (x[78:64] == EXP_BIAS && x[63:0] > MANT_ONE))
      return DEFAULT_NAN;
    if (x[78:0] == 0) return x;
    return c;
  endfunction
  // One instruction; class 0/1 zeros, 2 in range, 3 unit, 4 above one, 5 infinity, 6 NaN.
  task automatic run(input logic [15:0] o, input logic [15:0] c, input int cls);
    logic [79:0] x, cr, e;
    side_flags_t fl;
    logic m, bad, good;
    m = c[14];
    good = o[15:12] == LINE_F_CODE && o[11:9] == DEFAULT_CPID && c[6:0] == ARC_SINE_EXT;
    bad = m && (o[5:3] == 3'b001 || (o[5:3] == 3'b000 && c[12:10] inside {3'b010, 3'b011, 3'b101})
      || (o[5:3] == 3'b111 && o[2:0] > 3'b100) || c[12:10] == 3'b111);
    x = {cls == 1 || (cls > 1 && $urandom % 2 == 1), 79'h0};
    if (cls == 2) x[78:0] = {15'h_3FFE - 15'($urandom % 64), 1'b1, 63'({$urandom, $urandom})};
    if (cls > 2) x[78:0] = {cls == 5 ? EXP_ALL_ONES : EXP_BIAS, cls == 4 ? 64'h_C000_0000_0000_0001 : MANT_ONE};
    if (cls == 6) x[78:0] = {EXP_ALL_ONES, 2'b10, 30'h0, 32'($urandom) | 32'h_0000_0001};
    cr = {16'h_3FF0, 32'($urandom), 32'($urandom)};
    fl = side_flags_t'({1'b0, 3'($urandom)});
    issuer.issue(o, c);
    chk("accept", acc, good);
    if (!good) return;
    chk("illegal", ill, bad);
    chk("select", mem_src, m);
    chk("dst", dreg, c[9:7]);
    chk("src", m ? fmt : sreg, c[12:10]);
    if (m) chk("ea", ea, o[5:0]);
    if (m && !bad) chk("convert", conv, c[12:10] != FMT_EXTENDED);
    if (bad) return;
    issuer.give(x, cr, fl);
    e = model(x, cr);
    iop_acc = iop_acc | (e == DEFAULT_NAN);
    chk("we", we, 1'b1);
    chk("rreg", rreg, c[9:7]);
    chk("data", rdata, e);
    chk("operand_error_flag", status[EXC_OPERAND_ERROR_FLAG], e == DEFAULT_NAN);
    chk("clear", status[15:10] & 6'b10_0111, 6'h_00);
    chk("inexact_decimal_input_flag", status[EXC_INEXACT_DECIMAL_INPUT_FLAG], m && c[12:10] == FMT_PACKED && fl.inexact_decimal_input_flag);
    chk("iop", status[ACC_IOP], iop_acc);
    chk("quot", status[QUOT_HI:QUOT_LO], 8'h_00);
    chk("cc", status[CC_HI:CC_LO], {e[79], e[78:0] == 0, 1'b0, e[78:64] == EXP_ALL_ONES});
  endtask
  // Main sequence: register mode, memory formats, addressing, refusals.
  initial begin
    logic [5:0] s;
    void'($urandom(11803));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      s = 6'($urandom);
      run(16'h_F200, {3'b000, s[2:0], i == 0 ? s[2:0] : s[5:3], ARC_SINE_EXT}, i % 7);
    end
    for (int f = 0; f < 8; f++) begin
      run({10'h_3C8, 3'b111, 3'(f % 5)}, {3'b010, 3'(f), 3'(7 - f), ARC_SINE_EXT}, f % 6);
      run({10'h_3C8, 3'b000, 3'(f)}, {3'b010, 3'(f), 3'(f), ARC_SINE_EXT}, 2);
      run({10'h_3C8, f > 4 ? 3'b111 : 3'b001, 3'(f)}, {6'b010_001, 3'(f), ARC_SINE_EXT}, 2);
    end
    run(16'h_F400, {9'h_003, ARC_SINE_EXT}, 2);
    run(16'h_F200, {9'h_003, 7'h_0D}, 2);
    issuer.issue(16'h_F200, {9'h_005, ARC_SINE_EXT});
    chk("accept", acc, 1'b1);
    issuer.issue(16'h_F200, {9'h_005, ARC_SINE_EXT});
    chk("busy", acc, 1'b0);
    issuer.give({1'b1, 79'h0}, '0, '0);
    chk("zero", rdata, {1'b1, 79'h0});
    close_out();
  end
endmodule
